// File: design/eamc_top.sv
// energy accumulation mode control: mode registers, phase-b wiring, energy registers with read-clear
`timescale 1ns/1ns
`default_nettype none
`include "eamc_defs.svh"

// Functional notes
// - active mode 00, and reserved 01 and 10, accumulate total active power with its sign.
// - active mode 11 accumulates the absolute value of total active power.
// - reactive mode 00, and reserved 01 and 11, accumulate total reactive power with its sign.
// - reactive mode 10 adds reactive power as is when active power is positive and inverted when negative.
// - phases a and c always use their own inputs, apparent uses rms products; b uses own at 00, minus a at 11.
// - wiring 01 feeds zero into all phase b active, reactive and apparent accumulations.
// - wiring 10 takes phase b voltage as minus phase a voltage minus phase c voltage.
// - reactive power multiplies each voltage by its current shifted by minus ninety degrees.
// - line-cycle bit 0 moves the three active energy registers to line-cycle accumulation; resets to 0.
// - line-cycle bit 1 moves the three reactive energy registers to line-cycle accumulation; resets to 0.
// - line-cycle bit 2 moves the three apparent energy registers to line-cycle accumulation; resets to 0.
// - bits 3 to 5, reset to 1, pick phases a, b, c for crossing counts, more phases giving shorter periods.
// - with bit 6 at 1, its reset value, reading an energy register clears it; at 0 reads leave it.
// - reserved mode bits 7:6 and line-cycle bit 7 have no effect and reset to zero.
module eamc_top (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [15:0]            reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output var  logic [31:0]            reg_rdata,
    input  wire logic                   sample_valid,
    input  wire eamc_pkg::eamc_sample_t volt_a,
    input  wire eamc_pkg::eamc_sample_t volt_b,
    input  wire eamc_pkg::eamc_sample_t volt_c,
    input  wire eamc_pkg::eamc_sample_t curr_a,
    input  wire eamc_pkg::eamc_sample_t curr_b,
    input  wire eamc_pkg::eamc_sample_t curr_c,
    input  wire eamc_pkg::eamc_sample_t curr_q_a,
    input  wire eamc_pkg::eamc_sample_t curr_q_b,
    input  wire eamc_pkg::eamc_sample_t curr_q_c,
    input  wire eamc_pkg::eamc_rms_t    volt_rms_a,
    input  wire eamc_pkg::eamc_rms_t    volt_rms_b,
    input  wire eamc_pkg::eamc_rms_t    volt_rms_c,
    input  wire eamc_pkg::eamc_rms_t    curr_rms_a,
    input  wire eamc_pkg::eamc_rms_t    curr_rms_b,
    input  wire eamc_pkg::eamc_rms_t    curr_rms_c,
    input  wire logic [2:0]             zero_cross,
    output var  logic                   line_cycle_done
);
    import eamc_pkg::*;

    logic [7:0]              acc_mode_reg;
    logic [7:0]              lcyc_mode_reg;
    logic [15:0]             lcyc_count_reg;
    logic [8:0][31:0]        energy_reg;
    logic [8:0][31:0]        shadow_reg;

    eamc_act_mode_e          active_acc_mode;
    eamc_react_mode_e        reactive_acc_mode;
    eamc_wiring_e            wiring_select;
    logic [2:0]              lc_type_en;
    logic [2:0]              zero_cross_phase_select;
    logic                    read_clear_enable;

    logic signed [17:0]      va_x;
    logic signed [17:0]      vc_x;
    eamc_sample_t            vb_eff;
    logic                    kill_b;

    eamc_sample_t            volt_arr   [3];
    eamc_sample_t            curr_arr   [3];
    eamc_sample_t            curr_q_arr [3];
    eamc_rms_t               vrms_arr   [3];
    eamc_rms_t               irms_arr   [3];
    logic [2:0]              kill_arr;
    logic [2:0]              pwr_valid_arr;
    logic                    pwr_valid;
    logic [2:0][31:0]        act_pwr;
    logic [2:0][31:0]        react_pwr;
    logic [2:0][31:0]        app_pwr;
    logic [8:0][31:0]        add_term;
    logic [8:0]              rd_clear;
    logic                    lc_done;

    function automatic logic energy_hit(input logic [15:0] addr);
        return (addr >= `EAMC_ADDR_ENERGY_BASE) && (addr < (`EAMC_ADDR_ENERGY_BASE + 16'(`EAMC_NUM_ENERGY)));
    endfunction : energy_hit

    function automatic logic [3:0] energy_idx(input logic [15:0] addr);
        logic [15:0] off;
        off = addr - `EAMC_ADDR_ENERGY_BASE;
        return off[3:0];
    endfunction : energy_idx

    // clamps a widened voltage back into the sample range instead of wrapping
    function automatic eamc_sample_t eamc_sat16(input logic signed [17:0] x);
        if (x > 18'sh07fff)      return 16'sh7fff;
        else if (x < 18'sh38000) return 16'sh8000;
        else                     return x[15:0];
    endfunction : eamc_sat16

    // ---- mode registers; reserved bits are masked off on write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_mode_reg <= `EAMC_ACC_MODE_RST;
        end else if (reg_wr && reg_addr == `EAMC_ADDR_ACC_MODE) begin
            acc_mode_reg <= reg_wdata[7:0] & `EAMC_ACC_MODE_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lcyc_mode_reg <= `EAMC_LCYC_MODE_RST;
        end else if (reg_wr && reg_addr == `EAMC_ADDR_LCYC_MODE) begin
            lcyc_mode_reg <= reg_wdata[7:0] & `EAMC_LCYC_MODE_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lcyc_count_reg <= `EAMC_LCYC_COUNT_RST;
        end else if (reg_wr && reg_addr == `EAMC_ADDR_LCYC_COUNT) begin
            lcyc_count_reg <= reg_wdata[15:0];
        end
    end

    // reserved codes fall through to the signed behaviour by the enum compares downstream
    assign active_acc_mode         = eamc_act_mode_e'(acc_mode_reg[`EAMC_ACC_ACTIVE_MSB:`EAMC_ACC_ACTIVE_LSB]);
    assign reactive_acc_mode       = eamc_react_mode_e'(acc_mode_reg[`EAMC_ACC_REACT_MSB:`EAMC_ACC_REACT_LSB]);
    assign wiring_select           = eamc_wiring_e'(acc_mode_reg[`EAMC_ACC_WIRE_MSB:`EAMC_ACC_WIRE_LSB]);
    assign lc_type_en              = {lcyc_mode_reg[`EAMC_LCYC_APPARENT_BIT], lcyc_mode_reg[`EAMC_LCYC_REACT_BIT],
                                      lcyc_mode_reg[`EAMC_LCYC_ACTIVE_BIT]};
    assign zero_cross_phase_select = lcyc_mode_reg[`EAMC_LCYC_ZX_MSB:`EAMC_LCYC_ZX_LSB];
    assign read_clear_enable       = lcyc_mode_reg[`EAMC_LCYC_RCLR_BIT];

    // ---- phase b voltage by wiring
    assign va_x = {{2{volt_a[15]}}, volt_a};
    assign vc_x = {{2{volt_c[15]}}, volt_c};

    always_comb begin
        case (wiring_select)
            EAMC_WIRE_WYE_2V:   vb_eff = eamc_sat16(-va_x - vc_x);
            EAMC_WIRE_DELTA_4W: vb_eff = eamc_sat16(-va_x);
            default:            vb_eff = volt_b;
        endcase
    end

    assign kill_b = (wiring_select == EAMC_WIRE_DELTA_3W);

    assign volt_arr   = '{volt_a, vb_eff, volt_c};
    assign curr_arr   = '{curr_a, curr_b, curr_c};
    assign curr_q_arr = '{curr_q_a, curr_q_b, curr_q_c};
    assign vrms_arr   = '{volt_rms_a, volt_rms_b, volt_rms_c};
    assign irms_arr   = '{curr_rms_a, curr_rms_b, curr_rms_c};
    assign kill_arr   = {1'b0, kill_b, 1'b0};

    for (genvar ph = 0; ph < 3; ph++) begin : g_phase
        eamc_phase_power u_power (
            .clk           (clk),
            .rst_n         (rst_n),
            .in_valid      (sample_valid),
            .kill          (kill_arr[ph]),
            .volt          (volt_arr[ph]),
            .curr          (curr_arr[ph]),
            .curr_q        (curr_q_arr[ph]),
            .volt_rms      (vrms_arr[ph]),
            .curr_rms      (irms_arr[ph]),
            .active_mode   (active_acc_mode),
            .reactive_mode (reactive_acc_mode),
            .out_valid     (pwr_valid_arr[ph]),
            .active_pwr    (act_pwr[ph]),
            .reactive_pwr  (react_pwr[ph]),
            .apparent_pwr  (app_pwr[ph])
        );
    end

    assign pwr_valid = &pwr_valid_arr;

    eamc_line_cycle u_line_cycle (
        .clk          (clk),
        .rst_n        (rst_n),
        .enable       (|lc_type_en),
        .zero_cross   (zero_cross),
        .phase_select (zero_cross_phase_select),
        .target       (lcyc_count_reg),
        .done         (lc_done)
    );

    assign line_cycle_done = lc_done;

    // ---- energy terms and read-clear hits; index = type * 3 + phase
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            add_term[k]     = pwr_valid ? act_pwr[k]   : 32'h0;
            add_term[3 + k] = pwr_valid ? react_pwr[k] : 32'h0;
            add_term[6 + k] = pwr_valid ? app_pwr[k]   : 32'h0;
        end
        for (int k = 0; k < `EAMC_NUM_ENERGY; k++) begin
            rd_clear[k] = reg_rd && read_clear_enable && energy_hit(reg_addr)
                          && (energy_idx(reg_addr) == 4'(k));
        end
    end

    // a read-clear and a new term in the same cycle keep the term: the clear only drops the old total
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            energy_reg <= '0;
        end else begin
            for (int k = 0; k < `EAMC_NUM_ENERGY; k++) begin
                if (lc_type_en[k / 3]) begin
                    if (lc_done)          energy_reg[k] <= shadow_reg[k] + add_term[k];
                    else if (rd_clear[k]) energy_reg[k] <= 32'h0;
                end else begin
                    energy_reg[k] <= (rd_clear[k] ? 32'h0 : energy_reg[k]) + add_term[k];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shadow_reg <= '0;
        end else begin
            for (int k = 0; k < `EAMC_NUM_ENERGY; k++) begin
                if (!lc_type_en[k / 3] || lc_done) shadow_reg[k] <= 32'h0;
                else                               shadow_reg[k] <= shadow_reg[k] + add_term[k];
            end
        end
    end

    // ---- read port; data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            if (reg_addr == `EAMC_ADDR_ACC_MODE)        reg_rdata <= {24'h0, acc_mode_reg};
            else if (reg_addr == `EAMC_ADDR_LCYC_MODE)  reg_rdata <= {24'h0, lcyc_mode_reg};
            else if (reg_addr == `EAMC_ADDR_LCYC_COUNT) reg_rdata <= {16'h0, lcyc_count_reg};
            else if (energy_hit(reg_addr))              reg_rdata <= energy_reg[energy_idx(reg_addr)];
            else                                        reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ---- checks
    sequence s_clear_read;
        reg_rd && energy_hit(reg_addr) && read_clear_enable && !pwr_valid && !lc_done;
    endsequence

    sequence s_keep_read;
        reg_rd && energy_hit(reg_addr) && !read_clear_enable && !pwr_valid && !lc_done;
    endsequence

    sequence s_lc_close(int t);
        lc_done && lc_type_en[t] && !pwr_valid;
    endsequence

    AST_RESET_VALUES: assert property (@(posedge clk)
        !rst_n |=> acc_mode_reg == 8'h00 && lcyc_mode_reg == 8'h78 && lcyc_count_reg == 16'h0064)
        else $error("mode registers wrong after reset");
    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        acc_mode_reg[7:6] == 2'h0 && lcyc_mode_reg[7] == 1'b0)
        else $error("reserved bits became set");
    AST_VB_TWO_SENSOR: assert property (@(posedge clk) disable iff (!rst_n)
        wiring_select == EAMC_WIRE_WYE_2V && va_x + vc_x <= 18'sh07fff && va_x + vc_x >= 18'sh38001
        |-> {{2{vb_eff[15]}}, vb_eff} + va_x + vc_x == 18'h0)
        else $error("phase b voltage not minus a minus c");
    AST_VB_NEG_A: assert property (@(posedge clk) disable iff (!rst_n)
        wiring_select == EAMC_WIRE_DELTA_4W |-> (vb_eff == -volt_a) || (volt_a == 16'sh8000 && vb_eff == 16'sh7fff))
        else $error("phase b voltage not minus a");
    AST_DELTA_KILL: assert property (@(posedge clk) disable iff (!rst_n)
        sample_valid && wiring_select == EAMC_WIRE_DELTA_3W ##1 !lc_type_en[0] && !rd_clear[1]
        |-> pwr_valid ##1 energy_reg[1] == $past(energy_reg[1]))
        else $error("phase b active energy moved in three-wire delta");
    AST_READ_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        s_clear_read |=> energy_reg[energy_idx($past(reg_addr))] == 32'h0)
        else $error("read did not clear energy register");
    AST_READ_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
        s_keep_read |=> energy_reg == $past(energy_reg))
        else $error("read changed energy registers with read-clear off");
    AST_REGULAR_ACC: assert property (@(posedge clk) disable iff (!rst_n)
        !lc_type_en[0] && pwr_valid && !rd_clear[0] |=> energy_reg[0] == $past(energy_reg[0]) + $past(act_pwr[0]))
        else $error("regular active accumulation wrong");
    AST_LC_ACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
        s_lc_close(0) |=> energy_reg[0] == $past(shadow_reg[0]) && shadow_reg[0] == 32'h0)
        else $error("active line-cycle total not transferred");
    AST_LC_REACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
        s_lc_close(1) |=> energy_reg[4] == $past(shadow_reg[4]) && shadow_reg[4] == 32'h0)
        else $error("reactive line-cycle total not transferred");
    AST_LC_APPARENT: assert property (@(posedge clk) disable iff (!rst_n)
        s_lc_close(2) |=> energy_reg[8] == $past(shadow_reg[8]) && shadow_reg[8] == 32'h0)
        else $error("apparent line-cycle total not transferred");

endmodule : eamc_top

`default_nettype wire

// File: design/eamc_defs.svh
// register addresses, field positions, reset values and counts of the accumulation mode control block
`ifndef EAMC_DEFS_SVH
`define EAMC_DEFS_SVH

`define EAMC_ADDR_ACC_MODE      16'he701
`define EAMC_ADDR_LCYC_MODE     16'he702
`define EAMC_ADDR_LCYC_COUNT    16'he7f0
`define EAMC_ADDR_ENERGY_BASE   16'he400
`define EAMC_NUM_ENERGY         9

`define EAMC_ACC_ACTIVE_MSB     1
`define EAMC_ACC_ACTIVE_LSB     0
`define EAMC_ACC_REACT_MSB      3
`define EAMC_ACC_REACT_LSB      2
`define EAMC_ACC_WIRE_MSB       5
`define EAMC_ACC_WIRE_LSB       4

`define EAMC_LCYC_ACTIVE_BIT    0
`define EAMC_LCYC_REACT_BIT     1
`define EAMC_LCYC_APPARENT_BIT  2
`define EAMC_LCYC_ZX_MSB        5
`define EAMC_LCYC_ZX_LSB        3
`define EAMC_LCYC_RCLR_BIT      6

`define EAMC_ACC_MODE_RST       8'h00
`define EAMC_LCYC_MODE_RST      8'h78
`define EAMC_LCYC_COUNT_RST     16'h0064
`define EAMC_ACC_MODE_WMASK     8'h3f
`define EAMC_LCYC_MODE_WMASK    8'h7f

`endif

// File: design/eamc_pkg.sv
// types shared by the accumulation mode control block
package eamc_pkg;

    typedef logic signed [15:0] eamc_sample_t;
    typedef logic        [15:0] eamc_rms_t;
    typedef logic        [31:0] eamc_word_t;

    typedef enum logic [1:0] {
        EAMC_ACT_SIGNED = 2'b00,
        EAMC_ACT_RSV1   = 2'b01,
        EAMC_ACT_RSV2   = 2'b10,
        EAMC_ACT_ABS    = 2'b11
    } eamc_act_mode_e;

    typedef enum logic [1:0] {
        EAMC_REACT_SIGNED    = 2'b00,
        EAMC_REACT_RSV1      = 2'b01,
        EAMC_REACT_BY_ACTIVE = 2'b10,
        EAMC_REACT_RSV3      = 2'b11
    } eamc_react_mode_e;

    typedef enum logic [1:0] {
        EAMC_WIRE_WYE_3V   = 2'b00,
        EAMC_WIRE_DELTA_3W = 2'b01,
        EAMC_WIRE_WYE_2V   = 2'b10,
        EAMC_WIRE_DELTA_4W = 2'b11
    } eamc_wiring_e;

endpackage : eamc_pkg

// File: design/eamc_phase_power.sv
// per-phase power terms for one phase, shaped by the accumulation modes
`timescale 1ns/1ns
`default_nettype none

module eamc_phase_power (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     in_valid,
    input  wire logic                     kill,
    input  wire eamc_pkg::eamc_sample_t   volt,
    input  wire eamc_pkg::eamc_sample_t   curr,
    input  wire eamc_pkg::eamc_sample_t   curr_q,
    input  wire eamc_pkg::eamc_rms_t      volt_rms,
    input  wire eamc_pkg::eamc_rms_t      curr_rms,
    input  wire eamc_pkg::eamc_act_mode_e active_mode,
    input  wire eamc_pkg::eamc_react_mode_e reactive_mode,
    output var logic                      out_valid,
    output var eamc_pkg::eamc_word_t      active_pwr,
    output var eamc_pkg::eamc_word_t      reactive_pwr,
    output var eamc_pkg::eamc_word_t      apparent_pwr
);
    import eamc_pkg::*;

    logic signed [31:0] p_raw;
    logic signed [31:0] q_raw;
    logic        [31:0] s_raw;

    // 16x16 signed never reaches -2^31, so the absolute value cannot overflow
    assign p_raw = volt * curr;
    assign q_raw = volt * curr_q;
    assign s_raw = volt_rms * curr_rms;

    always_ff @(posedge clk) begin
        if (!rst_n) out_valid <= 1'b0;
        else        out_valid <= in_valid;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_pwr   <= 32'h0;
            reactive_pwr <= 32'h0;
            apparent_pwr <= 32'h0;
        end else if (in_valid) begin
            if (kill) begin
                active_pwr   <= 32'h0;
                reactive_pwr <= 32'h0;
                apparent_pwr <= 32'h0;
            end else begin
                active_pwr   <= (active_mode == EAMC_ACT_ABS && p_raw[31]) ? -p_raw : p_raw;
                reactive_pwr <= (reactive_mode == EAMC_REACT_BY_ACTIVE && p_raw[31]) ? -q_raw : q_raw;
                apparent_pwr <= s_raw;
            end
        end
    end

    AST_ACT_SIGNED: assert property (@(posedge clk) disable iff (!rst_n)
        in_valid && !kill && active_mode != EAMC_ACT_ABS |=> active_pwr == $past(p_raw))
        else $error("active power not passed with its sign");
    AST_ACT_ABS: assert property (@(posedge clk) disable iff (!rst_n)
        in_valid && !kill && active_mode == EAMC_ACT_ABS |=> !active_pwr[31] && (active_pwr == $past(p_raw)
        || active_pwr == -$past(p_raw)))
        else $error("absolute active power wrong");
    AST_REACT_FLIP: assert property (@(posedge clk) disable iff (!rst_n)
        in_valid && !kill && reactive_mode == EAMC_REACT_BY_ACTIVE && p_raw[31] |=> reactive_pwr == -$past(q_raw))
        else $error("reactive power not inverted for negative active power");
    AST_REACT_QUAD: assert property (@(posedge clk) disable iff (!rst_n)
        in_valid && !kill && reactive_mode != EAMC_REACT_BY_ACTIVE |=> reactive_pwr == $past(q_raw))
        else $error("signed reactive power wrong");
    AST_KILL_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        in_valid && kill |=> out_valid && active_pwr == 32'h0 && reactive_pwr == 32'h0 && apparent_pwr == 32'h0)
        else $error("killed phase produced power");

endmodule : eamc_phase_power

`default_nettype wire

// File: design/eamc_line_cycle.sv
// counts selected zero crossings and marks the end of each line-cycle accumulation period
`timescale 1ns/1ns
`default_nettype none

module eamc_line_cycle (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        enable,
    input  wire logic [2:0]  zero_cross,
    input  wire logic [2:0]  phase_select,
    input  wire logic [15:0] target,
    output var  logic        done
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [1:0]  hits;
    logic        fire;

    // every selected phase adds its crossings, so more phases end the period sooner
    always_comb begin
        hits     = 2'({1'b0, zero_cross[0] & phase_select[0]} + {1'b0, zero_cross[1] & phase_select[1]}
                   + {1'b0, zero_cross[2] & phase_select[2]});
        cnt_next = cnt_reg + {14'h0, hits};
        fire     = enable && (hits != 2'h0) && (cnt_next >= target);
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !enable) cnt_reg <= 16'h0;
        else if (fire)         cnt_reg <= 16'h0;
        else                   cnt_reg <= cnt_next;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) done <= 1'b0;
        else        done <= fire;
    end

    AST_LC_MULTI_PHASE: assert property (@(posedge clk) disable iff (!rst_n)
        enable && zero_cross == 3'h7 && phase_select == 3'h7 && target != 16'h0
        && (cnt_reg + 16'h3) >= target |=> done && cnt_reg == 16'h0)
        else $error("three selected crossings did not close the period");

endmodule : eamc_line_cycle

`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the accumulation mode control block
`timescale 1ns/1ns
`default_nettype none
`include "eamc_defs.svh"
module tb_top;
    logic               clk, rst_n, reg_wr, reg_rd, sample_valid;
    logic [15:0]        reg_addr;
    logic [31:0]        reg_wdata, reg_rdata, d;
    logic [2:0]         zero_cross;
    logic               line_cycle_done;
    logic signed [15:0] v[3], i[3], q[3];
    logic [15:0]        vr[3], ir[3];
    int                 err_total, num_checks, dn;
    eamc_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .volt_a(v[0]), .volt_b(v[1]),
        .volt_c(v[2]), .curr_a(i[0]), .curr_b(i[1]), .curr_c(i[2]), .curr_q_a(q[0]), .curr_q_b(q[1]),
        .curr_q_c(q[2]), .volt_rms_a(vr[0]), .volt_rms_b(vr[1]), .volt_rms_c(vr[2]), .curr_rms_a(ir[0]),
        .curr_rms_b(ir[1]), .curr_rms_c(ir[2]), .zero_cross(zero_cross), .line_cycle_done(line_cycle_done));
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (line_cycle_done === 1'b1) dn++;
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [31:0] w);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= w; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // data stand only in the cycle after the strobe, so sample just past that edge
    task rd(input logic [15:0] a);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task smp;
        @(posedge clk);
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : smp
    task zx(input logic [2:0] b);
        @(posedge clk);
        zero_cross <= b;
        @(posedge clk);
        zero_cross <= 3'h0;
    endtask : zx
    // expected energy after one sample from zero, index = type*3+phase
    function automatic logic [31:0] ex(int k, logic [7:0] m);
        logic signed [31:0] vv, a, r;
        int t, p;
        t = k / 3;
        p = k % 3;
        vv = v[p];
        if (p == 1 && m[5:4] == 2'b10) vv = -v[0] - v[2];
        if (p == 1 && m[5:4] == 2'b11) vv = -v[0];
        a = vv * i[p];
        r = vv * q[p];
        if (p == 1 && m[5:4] == 2'b01) return 32'h0;
        if (t == 2) return vr[p] * ir[p];
        if (t == 1) return (m[3:2] == 2'b10 && a < 0) ? -r : r;
        return (m[1:0] == 2'b11 && a < 0) ? -a : a;
    endfunction : ex
    task t_regs;
        rd(`EAMC_ADDR_ACC_MODE);  chk(d, 32'h0);
        rd(`EAMC_ADDR_LCYC_MODE); chk(d, 32'h78);
        rd(16'he7ff);             chk(d, 32'h0);
        wr(`EAMC_ADDR_ACC_MODE, 32'hff);
        wr(`EAMC_ADDR_LCYC_MODE, 32'hff);
        rd(`EAMC_ADDR_ACC_MODE);  chk(d, 32'h3f);
        rd(`EAMC_ADDR_LCYC_MODE); chk(d, 32'h7f);
        wr(`EAMC_ADDR_LCYC_MODE, 32'h78);
        $display("register test done");
    endtask : t_regs
    task t_modes;
        logic [7:0] tbl[11];
        tbl = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h30, 8'hc0};
        foreach (tbl[n]) begin
            wr(`EAMC_ADDR_ACC_MODE, {24'h0, tbl[n]});
            rd(`EAMC_ADDR_ACC_MODE); chk(d, {24'h0, tbl[n] & 8'h3f});
            smp;
            for (int k = 0; k < 9; k++) begin
                rd(`EAMC_ADDR_ENERGY_BASE + 16'(k));
                chk(d, ex(k, tbl[n]));
            end
        end
        $display("mode test done");
    endtask : t_modes
    task t_hold;
        wr(`EAMC_ADDR_LCYC_MODE, 32'h38);
        wr(`EAMC_ADDR_ACC_MODE, 32'h0);
        smp;
        rd(`EAMC_ADDR_ENERGY_BASE); chk(d, ex(0, 8'h0));
        rd(`EAMC_ADDR_ENERGY_BASE); chk(d, ex(0, 8'h0));
        wr(`EAMC_ADDR_LCYC_MODE, 32'h78);
        rd(`EAMC_ADDR_ENERGY_BASE); chk(d, ex(0, 8'h0));
        rd(`EAMC_ADDR_ENERGY_BASE); chk(d, 32'h0);
        $display("read-clear test done");
    endtask : t_hold
    task t_lcyc;
        wr(`EAMC_ADDR_LCYC_COUNT, 32'h2);
        wr(`EAMC_ADDR_LCYC_MODE, 32'h0f);
        dn = 0;
        smp;
        rd(`EAMC_ADDR_ENERGY_BASE); chk(d, 32'h0);
        repeat (3) zx(3'b010);
        repeat (4) @(posedge clk);
        chk(32'(dn), 32'h0);
        repeat (2) zx(3'b001);
        repeat (4) @(posedge clk);
        chk(32'(dn), 32'h1);
        rd(`EAMC_ADDR_ENERGY_BASE); chk(d, ex(0, 8'h0));
        // all three phases selected: one crossing on each closes a period of two
        wr(`EAMC_ADDR_LCYC_MODE, 32'h3f);
        zx(3'b111);
        repeat (4) @(posedge clk);
        chk(32'(dn), 32'h2);
        $display("line-cycle test done");
    endtask : t_lcyc
    initial begin
        rst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0; sample_valid = 0; zero_cross = 0;
        err_total = 0; num_checks = 0; dn = 0;
        v = '{-16'sd300, 16'sd200, 16'sd150};
        i = '{16'sd100, -16'sd50, 16'sd70};
        q = '{-16'sd40, 16'sd60, -16'sd20};
        vr = '{16'h0120, 16'h0130, 16'h0140};
        ir = '{16'h0021, 16'h0032, 16'h0043};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_modes;
        t_hold;
        t_lcyc;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up;
    end
endmodule : tb_top
`default_nettype wire
